// File: rtl/ebcfg_regs.sv
// Register bank and access specification of the external bus controller
//
// Summary of operation
// - Idle bit adds one state read-to-write; none added in multiplex mode
// - Select bit picks basic or burst ROM
// - Burst bits ignored in multiplex mode
// - Big area with chip select never bursts
// - Burst cycle lasts one or two states
// - Burst access limited to four or eight
// - Two-bit field picks I/O strobe range
// - Upper address drive, off in multiplex
// - Clock bit picks medium or system clock
// - Clock switches in the preceding cycle
// - Big area width bit: 16 or 8
// - Big area state bit: two or three
// - Basic area width bit: 16 or 8
// - Basic area state bit: two or three
// - Multiplex mode counts only data phase
// - Wait mode field selects four modes
// - Big area ignores basic area settings
// - Internal accesses keep fixed timing
// - Multiplex bit picks normal or multiplexed
// - Chip select asserted on big area
//
// Chosen here: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "ebcfg_consts.svh"
module ebcfg_regs
	import ebcfg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// AXI4-Lite slave
	input  wire logic [3:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	output logic [1:0]       s_axi_bresp_o,
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	input  wire logic [3:0]  s_axi_araddr_i,
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	// Bus cycle engine side
	input  wire ebcfg_req_s  req_i,
	output ebcfg_spec_s      spec_o,
	output logic             spec_valid_o
);

	logic [7:0] ext_bus_control;
	logic [7:0] ext_bus_control_second;
	logic [7:0] wait_state_control;
	logic [7:0] system_control_reg;
	logic       aw_held;
	logic       w_held;
	logic [3:0] aw_addr;
	logic [7:0] w_data;
	logic       w_lane0;
	logic       last_ext_read;
	logic       do_write;
	logic       wr_known;
	logic       rd_known;
	logic [7:0] rd_value;
	logic       in_big;
	logic       big_sel;
	logic       mux;
	ebcfg_spec_s next_spec;

	// Address and data are taken in any order, held until both arrived
	assign s_axi_awready_o = !aw_held && !s_axi_bvalid_o;
	assign s_axi_wready_o  = !w_held && !s_axi_bvalid_o;
	assign do_write        = aw_held && w_held && !s_axi_bvalid_o;

	// Write channel capture
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			aw_addr <= 4'h0;
			w_data  <= 8'h00;
			w_lane0 <= 1'b0;
		end else begin
			if (s_axi_awvalid_i && s_axi_awready_o) begin
				aw_held <= 1'b1;
				aw_addr <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && s_axi_wready_o) begin
				w_held  <= 1'b1;
				w_data  <= s_axi_wdata_i[7:0];
				w_lane0 <= s_axi_wstrb_i[0];
			end
			if (do_write) begin
				aw_held <= 1'b0;
				w_held  <= 1'b0;
			end
		end
	end

	// Write decode
	always_comb begin
		case ({aw_addr[3:2], 2'h0})
			`EBCFG_OFF_CTRL:  wr_known = 1'b1;
			`EBCFG_OFF_CTRL2: wr_known = 1'b1;
			`EBCFG_OFF_WAIT:  wr_known = 1'b1;
			`EBCFG_OFF_SYS:   wr_known = 1'b1;
			default:          wr_known = 1'b0;
		endcase
	end

	// Register storage; reserved bits hold their reset value
	// reset values
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			ext_bus_control        <= `EBCFG_RST_CTRL;
			ext_bus_control_second <= `EBCFG_RST_CTRL2;
			wait_state_control     <= `EBCFG_RST_WAIT;
			system_control_reg     <= `EBCFG_RST_SYS;
		end else if (do_write && w_lane0) begin
			case ({aw_addr[3:2], 2'h0})
				`EBCFG_OFF_CTRL: ext_bus_control <=
					(w_data & `EBCFG_WM_CTRL) |
					(`EBCFG_RST_CTRL & ~`EBCFG_WM_CTRL);
				`EBCFG_OFF_CTRL2: ext_bus_control_second <=
					(w_data & `EBCFG_WM_CTRL2) |
					(`EBCFG_RST_CTRL2 & ~`EBCFG_WM_CTRL2);
				`EBCFG_OFF_WAIT: wait_state_control <=
					(w_data & `EBCFG_WM_WAIT) |
					(`EBCFG_RST_WAIT & ~`EBCFG_WM_WAIT);
				`EBCFG_OFF_SYS: system_control_reg <=
					(w_data & `EBCFG_WM_SYS) |
					(`EBCFG_RST_SYS & ~`EBCFG_WM_SYS);
				default: ;
			endcase
		end
	end

	// Write response; bits 3:2 decode all four offsets, so every write answers OKAY
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o  <= `EBCFG_RESP_OKAY;
		end else if (do_write) begin
			s_axi_bvalid_o <= 1'b1;
			s_axi_bresp_o  <= wr_known ? `EBCFG_RESP_OKAY : `EBCFG_RESP_SLVERR;
		end else if (s_axi_bready_i) begin
			s_axi_bvalid_o <= 1'b0;
		end
	end

	// Read decode
	always_comb begin
		rd_known = 1'b1;
		case ({s_axi_araddr_i[3:2], 2'h0})
			`EBCFG_OFF_CTRL:  rd_value = ext_bus_control;
			`EBCFG_OFF_CTRL2: rd_value = ext_bus_control_second;
			`EBCFG_OFF_WAIT:  rd_value = wait_state_control;
			`EBCFG_OFF_SYS:   rd_value = system_control_reg;
			default: begin
				rd_value = 8'h00;
				rd_known = 1'b0;
			end
		endcase
	end

	assign s_axi_arready_o = !s_axi_rvalid_o;

	// Read data path
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o  <= 32'h00000000;
			s_axi_rresp_o  <= `EBCFG_RESP_OKAY;
		end else if (s_axi_arvalid_i && s_axi_arready_o) begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rdata_o  <= {24'h000000, rd_value};
			s_axi_rresp_o  <= rd_known ? `EBCFG_RESP_OKAY : `EBCFG_RESP_SLVERR;
		end else if (s_axi_rready_i) begin
			s_axi_rvalid_o <= 1'b0;
		end
	end

	// Area decode of the requested address
	// mux mode select
	assign mux    = system_control_reg[`EBCFG_B_MUX];
	assign in_big = (req_i.addr >= `EBCFG_BIG_BASE) &&
		(req_i.addr <= `EBCFG_BIG_LAST);
	assign big_sel = in_big && system_control_reg[`EBCFG_B_BIG_CS];

	// Specification for the access about to start
	always_comb begin
		next_spec = '0;
		if (!req_i.is_ext) begin
			next_spec.states = `EBCFG_STATES_TWO;
			next_spec.fast_clock = 1'b1;
		end else begin
			next_spec.mux_mode = mux;
			next_spec.io_range = {ext_bus_control[`EBCFG_B_IOS_HI],
				ext_bus_control[`EBCFG_B_IOS_LO]};
			next_spec.fast_clock = ext_bus_control_second[`EBCFG_B_EXT_CLK];
			next_spec.upper_addr_en = !mux &&
				ext_bus_control_second[`EBCFG_B_UPPER_ADDR];
			next_spec.big_cs = big_sel;
			next_spec.insert_idle = !mux && req_i.is_write &&
				last_ext_read && ext_bus_control[`EBCFG_B_IDLE];
			next_spec.data_phase_only = mux;
			if (big_sel) begin
				next_spec.width8 = wait_state_control[`EBCFG_B_BIG_WIDTH];
				next_spec.wait_en = wait_state_control[`EBCFG_B_BIG_STATE];
				next_spec.states = next_spec.wait_en ?
					`EBCFG_STATES_THREE : `EBCFG_STATES_TWO;
				next_spec.wait_mode = EBCFG_WAIT_PROGRAM;
			end else begin
				next_spec.width8 = wait_state_control[`EBCFG_B_BAS_WIDTH];
				next_spec.wait_en = wait_state_control[`EBCFG_B_BAS_STATE];
				next_spec.states = next_spec.wait_en ?
					`EBCFG_STATES_THREE : `EBCFG_STATES_TWO;
				next_spec.wait_mode = next_spec.wait_en ?
					ebcfg_wait_e'({wait_state_control[`EBCFG_B_WMODE_HI],
					wait_state_control[`EBCFG_B_WMODE_LO]}) :
					EBCFG_WAIT_NONE;
				next_spec.use_burst = !mux &&
					ext_bus_control[`EBCFG_B_BURST_ROM];
			end
			if (next_spec.use_burst) begin
				next_spec.burst_states =
					ext_bus_control[`EBCFG_B_BURST_LEN] ?
					`EBCFG_BURST_ST_TWO : `EBCFG_BURST_ST_ONE;
				next_spec.burst_words =
					ext_bus_control[`EBCFG_B_BURST_WORDS] ?
					`EBCFG_BURST_LONG : `EBCFG_BURST_SHORT;
			end
		end
	end

	// Specification sampled at access start
	// sample at start
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			spec_o       <= '0;
			spec_valid_o <= 1'b0;
		end else begin
			spec_valid_o <= req_i.start;
			if (req_i.start) begin
				spec_o <= next_spec;
			end
		end
	end

	// Track whether the last access started was an external read
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			last_ext_read <= 1'b0;
		end else if (req_i.start) begin
			last_ext_read <= req_i.is_ext && !req_i.is_write;
		end
	end

endmodule : ebcfg_regs

// File: rtl/ebcfg_consts.svh
// Offsets, field positions, reset values and timing counts of the bus config block
`ifndef EBCFG_CONSTS_SVH
`define EBCFG_CONSTS_SVH
// Register byte offsets
`define EBCFG_OFF_CTRL        4'h0
`define EBCFG_OFF_CTRL2       4'h4
`define EBCFG_OFF_WAIT        4'h8
`define EBCFG_OFF_SYS         4'hC
// Reset values
`define EBCFG_RST_CTRL        8'hD3
`define EBCFG_RST_CTRL2       8'h32
`define EBCFG_RST_WAIT        8'hF3
`define EBCFG_RST_SYS         8'h00
// Control register fields
`define EBCFG_B_IDLE          6
`define EBCFG_B_BURST_ROM     5
`define EBCFG_B_BURST_LEN     4
`define EBCFG_B_BURST_WORDS   3
`define EBCFG_B_IOS_HI        1
`define EBCFG_B_IOS_LO        0
// Second control register fields
`define EBCFG_B_UPPER_ADDR    3
`define EBCFG_B_EXT_CLK       2
// Wait state control fields
`define EBCFG_B_BIG_WIDTH     7
`define EBCFG_B_BIG_STATE     6
`define EBCFG_B_BAS_WIDTH     5
`define EBCFG_B_BAS_STATE     4
`define EBCFG_B_WMODE_HI      3
`define EBCFG_B_WMODE_LO      2
// Own system control fields
`define EBCFG_B_BIG_CS        1
`define EBCFG_B_MUX           0
// Writable masks: reserved bits keep their reset value
`define EBCFG_WM_CTRL         8'h7B
`define EBCFG_WM_CTRL2        8'h0C
`define EBCFG_WM_WAIT         8'hFC
`define EBCFG_WM_SYS          8'h03
// Big area address window
`define EBCFG_BIG_BASE        24'hF80000
`define EBCFG_BIG_LAST        24'hFBFFFF
// Burst limits and state counts
`define EBCFG_BURST_SHORT     4'h4
`define EBCFG_BURST_LONG      4'h8
`define EBCFG_STATES_TWO      2'h2
`define EBCFG_STATES_THREE    2'h3
`define EBCFG_BURST_ST_ONE    2'h1
`define EBCFG_BURST_ST_TWO    2'h2
// AXI response codes
`define EBCFG_RESP_OKAY       2'h0
`define EBCFG_RESP_SLVERR     2'h2
`endif

// File: rtl/ebcfg_pkg.sv
// Types shared by the bus config block
package ebcfg_pkg;
	// Wait mode of the basic area
	typedef enum logic [1:0] {
		EBCFG_WAIT_PROGRAM,
		EBCFG_WAIT_NONE,
		EBCFG_WAIT_PIN,
		EBCFG_WAIT_PIN_AUTO
	} ebcfg_wait_e;

	// Access request from the bus cycle engine
	typedef struct packed {
		logic        start;
		logic [23:0] addr;
		logic        is_write;
		logic        is_ext;
	} ebcfg_req_s;

	// Bus specification for the access being started
	typedef struct packed {
		logic        use_burst;
		logic [1:0]  burst_states;
		logic [3:0]  burst_words;
		logic        width8;
		logic [1:0]  states;
		logic        wait_en;
		ebcfg_wait_e wait_mode;
		logic        data_phase_only;
		logic        big_cs;
		logic        insert_idle;
		logic        fast_clock;
		logic        upper_addr_en;
		logic [1:0]  io_range;
		logic        mux_mode;
	} ebcfg_spec_s;
endpackage : ebcfg_pkg

// File: verif/ebcfg_engine_model.sv
// Bus cycle engine model that issues access starts to the config block
`timescale 1ns/1ps
module ebcfg_engine_model
	import ebcfg_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        go_i,
	input  wire logic [23:0] addr_i,
	input  wire logic        wr_i,
	input  wire logic        ext_i,
	output ebcfg_req_s       req_o
);
	// start pulse with qualifiers
	// Outside a start the qualifiers scramble, as a real engine may
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			req_o <= '0;
		end else begin
			req_o.start    <= go_i;
			req_o.addr     <= go_i ? addr_i : ~req_o.addr;
			req_o.is_write <= go_i ? wr_i : ~req_o.is_write;
			req_o.is_ext   <= go_i ? ext_i : ~req_o.is_ext;
		end
	end
endmodule : ebcfg_engine_model

// File: verif/ebcfg_regs_monitor.sv
// Assertion checker for the bus config register block
`timescale 1ns/1ps
module ebcfg_regs_monitor
	import ebcfg_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        s_axi_arvalid_i,
	input wire logic        s_axi_arready_o,
	input wire logic        s_axi_rvalid_o,
	input wire logic        s_axi_rready_i,
	input wire logic [31:0] s_axi_rdata_o,
	input wire logic [1:0]  s_axi_rresp_o,
	input wire logic        s_axi_bvalid_o,
	input wire logic        s_axi_bready_i,
	input wire logic [1:0]  s_axi_bresp_o,
	input wire ebcfg_req_s  req_i,
	input wire ebcfg_spec_s spec_o,
	input wire logic        spec_valid_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_spec_pulse: assert property (req_i.start |=> spec_valid_o)
		else $error("spec valid missing after start");
	a_valid_cause: assert property (spec_valid_o |-> $past(req_i.start))
		else $error("spec valid without start");
	a_spec_held: assert property (!req_i.start |=> $stable(spec_o))
		else $error("spec changed without start");
	a_int_fixed: assert property (req_i.start && !req_i.is_ext |=>
		spec_o.states == 2'h2 && spec_o.fast_clock && !spec_o.use_burst)
		else $error("internal access timing not fixed");
	a_big_noburst: assert property (spec_valid_o && spec_o.big_cs |->
		!spec_o.use_burst) else $error("burst on big area");
	a_mux_ignore: assert property (spec_valid_o && spec_o.mux_mode |->
		!spec_o.use_burst && !spec_o.insert_idle)
		else $error("burst or idle in multiplex mode");
	a_read_lat: assert property (s_axi_arvalid_i && s_axi_arready_o |=>
		s_axi_rvalid_o && s_axi_rdata_o[31:8] == 24'h0 && s_axi_rresp_o == 2'h0)
		else $error("read answer wrong");
	a_resp_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=>
		s_axi_bvalid_o && s_axi_bresp_o == 2'h0)
		else $error("write response dropped");
endmodule : ebcfg_regs_monitor
bind ebcfg_regs ebcfg_regs_monitor ebcfg_regs_monitor_i (.clk_i, .rst_i,
	.s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rvalid_o, .s_axi_rready_i,
	.s_axi_rdata_o, .s_axi_rresp_o, .s_axi_bvalid_o, .s_axi_bready_i,
	.s_axi_bresp_o, .req_i, .spec_o, .spec_valid_o);

// File: verif/ext_bus_config_regs_test.sv
// Self-checking bench of the bus config register block
`timescale 1ns/1ps
`include "ebcfg_consts.svh"
module ext_bus_config_regs_test;
	import ebcfg_pkg::*;
	logic clk_i = 0, rst_i = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
	logic [3:0] aw_a = 0, w_s = 0, ar_a = 0;
	logic [31:0] w_d = 0, r_d;
	logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, go = 0, wr = 0, ex = 0, sv;
	logic [1:0] b_rs, r_rs;
	logic [23:0] ad = 0;
	logic [7:0] rg [4], wm [4];
	logic prev_rd;
	ebcfg_req_s req;
	ebcfg_spec_s spec;
	int err_total = 0, tests_run = 0;
	// Clock of 8 ns
	initial forever #4 clk_i = ~clk_i;
	ebcfg_engine_model ebcfg_engine_model_i (.clk_i, .rst_i, .go_i(go),
		.addr_i(ad), .wr_i(wr), .ext_i(ex), .req_o(req));
	ebcfg_regs ebcfg_regs_i (.clk_i, .rst_i, .s_axi_awaddr_i(aw_a),
		.s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_wdata_i(w_d),
		.s_axi_wstrb_i(w_s), .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy),
		.s_axi_bresp_o(b_rs), .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r),
		.s_axi_araddr_i(ar_a), .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy),
		.s_axi_rdata_o(r_d), .s_axi_rresp_o(r_rs), .s_axi_rvalid_o(r_v),
		.s_axi_rready_i(r_r), .req_i(req), .spec_o(spec), .spec_valid_o(sv));
	task automatic wrap_up;
		$display("Checks %0d, mismatches %0d", tests_run, err_total);
		if (err_total == 0 && tests_run > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : wrap_up
	task automatic do_reset;
		rst_i <= 1;
		repeat (8) @(posedge clk_i);
		rst_i <= 0;
		rg = '{8'hD3, 8'h32, 8'hF3, 8'h00};
		prev_rd = 0;
	endtask : do_reset
	task automatic axw(input logic [1:0] i, input logic [7:0] d, input logic s);
		logic a, w, rb;
		a = 0;
		w = 0;
		rb = 1'($urandom);
		aw_a <= {i, 2'h0}; w_d <= {24'($urandom), d}; w_s <= {3'($urandom), s};
		aw_v <= 1; w_v <= 1; b_r <= rb;
		do begin
			@(posedge clk_i);
			if (aw_rdy) a = 1;
			if (w_rdy) w = 1;
			if (a) aw_v <= 0;
			if (w) w_v <= 0;
		end while (!(a && w));
		while (b_v !== 1'b1) @(posedge clk_i);
		tests_run++;
		if (b_rs !== `EBCFG_RESP_OKAY) begin
			err_total++;
			$display("BAD %0t write response %h", $time, b_rs);
		end
		// Late ready keeps the response waiting one cycle
		if (!rb) begin
			b_r <= 1;
			@(posedge clk_i);
		end
		if (s) rg[i] = (rg[i] & ~wm[i]) | (d & wm[i]);
	endtask : axw
	task automatic chk_reg(input logic [1:0] i);
		ar_a <= {i, 2'h0}; ar_v <= 1; r_r <= 1;
		do @(posedge clk_i); while (ar_rdy !== 1'b1);
		ar_v <= 0;
		do @(posedge clk_i); while (r_v !== 1'b1);
		tests_run++;
		if (r_rs !== `EBCFG_RESP_OKAY) begin
			err_total++;
			$display("BAD %0t read response %h", $time, r_rs);
		end
		tests_run++;
		if (r_d !== {24'h0, rg[i]}) begin
			err_total++;
			$display("BAD %0t reg %0d read %h", $time, i, r_d);
		end
	endtask : chk_reg
	function automatic ebcfg_spec_s exp_spec(logic [23:0] a, logic w, logic e);
		ebcfg_spec_s s;
		logic big, mux;
		s = '0;
		mux = rg[3][0];
		big = rg[3][1] && a >= `EBCFG_BIG_BASE && a <= `EBCFG_BIG_LAST;
		if (!e) begin
			s.states = 2'h2;
			s.fast_clock = 1;
			return s;
		end
		s.mux_mode = mux; s.data_phase_only = mux; s.big_cs = big;
		s.io_range = rg[0][1:0]; s.fast_clock = rg[1][2];
		s.upper_addr_en = rg[1][3] && !mux;
		s.use_burst = rg[0][5] && !mux && !big;
		if (s.use_burst) s.burst_states = rg[0][4] ? 2'h2 : 2'h1;
		if (s.use_burst) s.burst_words = rg[0][3] ? 4'h8 : 4'h4;
		s.width8 = big ? rg[2][7] : rg[2][5];
		s.wait_en = big ? rg[2][6] : rg[2][4];
		s.states = s.wait_en ? 2'h3 : 2'h2;
		s.wait_mode = big ? EBCFG_WAIT_PROGRAM :
			(s.wait_en ? ebcfg_wait_e'(rg[2][3:2]) : EBCFG_WAIT_NONE);
		s.insert_idle = rg[0][6] && w && prev_rd && !mux;
		return s;
	endfunction : exp_spec
	task automatic rq(input logic [23:0] a, input logic w, input logic e);
		ebcfg_spec_s x;
		int n;
		x = exp_spec(a, w, e);
		go <= 1; ad <= a; wr <= w; ex <= e;
		@(posedge clk_i);
		go <= 0;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sv !== 1'b1 && n < 8);
		tests_run++;
		if (spec !== x) begin
			err_total++;
			$display("BAD %0t spec %h expected %h", $time, spec, x);
		end
		prev_rd = e && !w;
	endtask : rq
	initial begin
		#400000;
		err_total++;
		wrap_up();
	end
	initial begin
		wm = '{8'h7B, 8'h0C, 8'hFC, 8'h03};
		void'($urandom(90));
		do_reset();
		for (int i = 0; i < 4; i++) chk_reg(i);
		for (int i = 0; i < 4; i++) begin
			axw(i, 8'hFF, 1);
			chk_reg(i);
			axw(i, 8'h00, 0);
			chk_reg(i);
		end
		for (int n = 0; n < 200; n++) begin
			if (n % 4 == 0) for (int i = 0; i < 4; i++) axw(i, $urandom, 1);
			case ($urandom % 3)
				0: ad = 24'hF80000 | 24'($urandom % 24'h40000);
				1: ad = 24'($urandom);
				default: ad = 24'hFFF000 | 24'($urandom % 24'h800);
			endcase
			rq(ad, $urandom, $urandom % 4 != 0);
			rq(ad ^ 24'h4, 1, 1);
		end
		do_reset();
		for (int i = 0; i < 4; i++) chk_reg(i);
		rq(24'hF90000, 0, 1);
		rq(24'hF90000, 1, 1);
		wrap_up();
	end
endmodule : ext_bus_config_regs_test
